// File: hdl/tcp_defs.vh
// tcp_defs.vh: register map, field positions and codes of the compare timer
// assumes byte addressing on a 32-bit Avalon-MM slave
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH
`define TCP_AW 12
`define TCP_A_MODE 12'h0100
`define TCP_A_CTL1 12'h0104
`define TCP_A_IOC 12'h0108
`define TCP_A_CNT 12'h010C
`define TCP_A_GRA 12'h0110
`define TCP_A_GRB 12'h0114
`define TCP_A_GRC 12'h0118
`define TCP_A_GRD 12'h011C
`define TCP_A_STAT 12'h0120
`define TCP_A_IEN 12'h0124
`define TCP_A_CCR2 12'h0130
`define TCP_CCR2_RST 8'h18
`define TCP_CCR2_ONES 8'h18
`define TCP_CCR2_POL 2:0
`define TCP_CCR2_STOP 5
`define TCP_CCR2_EDGE 7:6
`define TCP_M_START 0
`define TCP_M_PWM 1
`define TCP_M_BFC 2
`define TCP_M_BFD 3
`define TCP_M_PEN 6:4
`define TCP_M_CUT 7
`define TCP_C1_TOA 0
`define TCP_C1_TOX 3:1
`define TCP_C1_SRC 6:4
`define TCP_C1_CCLR 7
`define TCP_IOC_SELC 8
`define TCP_IOC_SELD 9
`define TCP_IOC_A 1:0
`define TCP_IOC_C 5:4
`define TCP_IOC_D 7:6
`define TCP_SYNC_CUT 4
`define TCP_SRC_F1 3'h0
`define TCP_SRC_F2 3'h1
`define TCP_SRC_F4 3'h2
`define TCP_SRC_F8 3'h3
`define TCP_SRC_F32 3'h4
`define TCP_SRC_EXT 3'h5
`define TCP_SRC_FOSC 3'h6
`define TCP_SRC_DOSC 3'h7
`define TCP_F2_MASK 5'h01
`define TCP_F4_MASK 5'h03
`define TCP_F8_MASK 5'h07
`define TCP_F32_MASK 5'h1F
`define TCP_CNT_MAX 16'hFFFF
`define TCP_ACT_HOLD 2'h0
`define TCP_ACT_LOW 2'h1
`define TCP_ACT_HIGH 2'h2
`define TCP_EDGE_RISE 2'h1
`define TCP_EDGE_FALL 2'h2
`define TCP_EDGE_BOTH 2'h3
`define TCP_ST_OVF 4
`define TCP_ST_TRG 5
`define TCP_NFLAG 6
`endif

// File: hdl/tcp_timer_compare_pwm_unit.v
// tcp_timer_compare_pwm_unit.v: 16-bit compare timer with pwm mode
// assumes one clock, synchronous reset, avalon-mm slave, async pins
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tcp_defs.vh"
module tcp_timer_compare_pwm_unit (
  input wire mclk_in,
  input wire srst_in,
  input wire ce_in,
  input wire [11:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire external_count_clock_pin_in,
  input wire fast_osc_clock_in,
  input wire divided_osc_clock_in,
  input wire trigger_input_pin_in,
  input wire cutoff_in,
  output wire [3:0] output_pin_out,
  output wire [3:0] output_pin_oe_out,
  output wire adc_trigger_out,
  output wire irq_out
);
  reg [31:0] rdata_q;
  reg wait_q;
  reg [7:0] mode_q;
  reg [7:0] ctl1_q;
  reg [9:0] ioc_q;
  reg [7:0] ccr2_q;
  reg [15:0] cnt_q;
  reg [15:0] gr_q [0:3];
  reg [`TCP_NFLAG-1:0] flag_q;
  reg [`TCP_NFLAG-1:0] ien_q;
  wire [3:0] pin_q;
  wire [3:0] oe_q;
  reg pin_a_q;
  reg oe_a_q;
  reg adc_q;
  reg irq_q;
  reg [4:0] div_q;
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg [3:0] s3_q;
  reg [31:0] rd_d;
  reg tick;
  reg [`TCP_NFLAG-1:0] set_d;
  wire [3:0] mt;
  wire run;
  wire acc;
  wire wr;
  wire pwm;
  wire ctl1_wr;
  wire ext_rise;
  wire fo_rise;
  wire do_rise;
  wire trg_rise;
  wire trg_fall;
  wire trg_evt;
  wire stop_a;
  wire [1:0] edge_sel;
  wire oe_a_d;
  wire a_nowrap;
  wire ovf_set;
  wire stat_wr;
  wire cut_act;

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign output_pin_out = pin_q;
  assign output_pin_oe_out = oe_q;
  assign adc_trigger_out = adc_q;
  assign irq_out = irq_q;

  assign acc = ~wait_q & (avs_read_in | avs_write_in);
  assign wr = ~wait_q & avs_write_in;
  assign ctl1_wr = wr & (avs_address_in == `TCP_A_CTL1);
  assign pwm = mode_q[`TCP_M_PWM];
  assign run = mode_q[`TCP_M_START] & tick;
  assign stop_a = ccr2_q[`TCP_CCR2_STOP];
  assign edge_sel = ccr2_q[`TCP_CCR2_EDGE];
  assign stat_wr = wr & (avs_address_in == `TCP_A_STAT);
  assign cut_act = mode_q[`TCP_M_CUT] & s2_q[`TCP_SYNC_CUT];

  // no wrap when match a clears or stops the counter
  assign a_nowrap = mt[0] & (stop_a | pwm | ctl1_q[`TCP_C1_CCLR]);
  assign ovf_set = run & (cnt_q == `TCP_CNT_MAX) & ~a_nowrap;

  // two-flop synchronisers for pins and foreign clocks
  always @(posedge mclk_in) begin
    if (srst_in) begin
      s1_q <= 5'h0_0;
      s2_q <= 5'h0_0;
      s3_q <= 4'h0;
    end else if (ce_in) begin
      s1_q <= {cutoff_in, trigger_input_pin_in, divided_osc_clock_in,
               fast_osc_clock_in, external_count_clock_pin_in};
      s2_q <= s1_q;
      s3_q <= s2_q[3:0];
    end
  end
  assign ext_rise = s2_q[0] & ~s3_q[0];
  assign fo_rise = s2_q[1] & ~s3_q[1];
  assign do_rise = s2_q[2] & ~s3_q[2];
  assign trg_rise = s2_q[3] & ~s3_q[3];
  assign trg_fall = ~s2_q[3] & s3_q[3];
  // trigger edge detection
  assign trg_evt = (edge_sel == `TCP_EDGE_RISE) ? trg_rise :
                   (edge_sel == `TCP_EDGE_FALL) ? trg_fall :
                   (edge_sel == `TCP_EDGE_BOTH) ? (trg_rise | trg_fall) : 1'b0;

  // count source select
  always @* begin
    case (ctl1_q[`TCP_C1_SRC])
      `TCP_SRC_F1: tick = 1'b1;
      `TCP_SRC_F2: tick = ((div_q & `TCP_F2_MASK) == `TCP_F2_MASK);
      `TCP_SRC_F4: tick = ((div_q & `TCP_F4_MASK) == `TCP_F4_MASK);
      `TCP_SRC_F8: tick = ((div_q & `TCP_F8_MASK) == `TCP_F8_MASK);
      `TCP_SRC_F32: tick = (div_q == `TCP_F32_MASK);
      `TCP_SRC_EXT: tick = ext_rise;
      `TCP_SRC_FOSC: tick = fo_rise;
      `TCP_SRC_DOSC: tick = do_rise;
      default: tick = 1'b0;
    endcase
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      div_q <= 5'h0_0;
    end else if (ce_in) begin
      div_q <= div_q + 5'h0_1;
    end
  end

  // compare matches per register
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_mt
      assign mt[g] = run & (cnt_q == gr_q[g]);
    end
  endgenerate

  // read mux
  always @* begin
    rd_d = 32'h0000_0000;
    case (avs_address_in)
      `TCP_A_MODE: rd_d[7:0] = mode_q;
      `TCP_A_CTL1: rd_d[7:0] = ctl1_q;
      `TCP_A_IOC: rd_d[9:0] = ioc_q;
      `TCP_A_CNT: rd_d[15:0] = cnt_q;
      `TCP_A_GRA: rd_d[15:0] = gr_q[0];
      `TCP_A_GRB: rd_d[15:0] = gr_q[1];
      `TCP_A_GRC: rd_d[15:0] = gr_q[2];
      `TCP_A_GRD: rd_d[15:0] = gr_q[3];
      `TCP_A_STAT: rd_d[`TCP_NFLAG-1:0] = flag_q;
      `TCP_A_IEN: rd_d[`TCP_NFLAG-1:0] = ien_q;
      `TCP_A_CCR2: rd_d[7:0] = ccr2_q | `TCP_CCR2_ONES;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // avalon slave: one wait cycle, then a single-cycle accept
  always @(posedge mclk_in) begin
    if (srst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (wait_q & (avs_read_in | avs_write_in)) begin
        wait_q <= 1'b0;
        rdata_q <= rd_d;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  // control registers and counter
  always @(posedge mclk_in) begin
    if (srst_in) begin
      mode_q <= 8'h00;
      ctl1_q <= 8'h00;
      ioc_q <= 10'h000;
      ccr2_q <= `TCP_CCR2_RST;
      ien_q <= {`TCP_NFLAG{1'b0}};
      cnt_q <= 16'h0000;
      gr_q[0] <= `TCP_CNT_MAX;
      gr_q[1] <= `TCP_CNT_MAX;
      gr_q[2] <= `TCP_CNT_MAX;
      gr_q[3] <= `TCP_CNT_MAX;
    end else if (ce_in) begin
      if (run) begin
        if (mt[0] & stop_a) begin
          mode_q[`TCP_M_START] <= 1'b0;
        end else if (mt[0] & (pwm | ctl1_q[`TCP_C1_CCLR])) begin
          cnt_q <= 16'h0000;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
        if (mt[0] & pwm & mode_q[`TCP_M_BFC]) begin
          gr_q[0] <= gr_q[2];
        end
        if (mt[0] & pwm & mode_q[`TCP_M_BFD]) begin
          gr_q[1] <= gr_q[3];
        end
      end
      if (wr) begin
        case (avs_address_in)
          `TCP_A_MODE: mode_q <= avs_writedata_in[7:0];
          `TCP_A_CTL1: ctl1_q <= avs_writedata_in[7:0];
          `TCP_A_IOC: ioc_q <= avs_writedata_in[9:0];
          `TCP_A_CNT: cnt_q <= avs_writedata_in[15:0];
          `TCP_A_GRA: gr_q[0] <= avs_writedata_in[15:0];
          `TCP_A_GRB: gr_q[1] <= avs_writedata_in[15:0];
          `TCP_A_GRC: gr_q[2] <= avs_writedata_in[15:0];
          `TCP_A_GRD: gr_q[3] <= avs_writedata_in[15:0];
          `TCP_A_IEN: ien_q <= avs_writedata_in[`TCP_NFLAG-1:0];
          `TCP_A_CCR2: ccr2_q <= avs_writedata_in[7:0] | `TCP_CCR2_ONES;
          default: ;
        endcase
      end
    end
  end

  // sticky flags, set wins over write-one-to-clear
  always @* begin
    set_d = {`TCP_NFLAG{1'b0}};
    set_d[3:0] = mt;
    set_d[`TCP_ST_OVF] = ovf_set;
    set_d[`TCP_ST_TRG] = trg_evt;
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      flag_q <= {`TCP_NFLAG{1'b0}};
      irq_q <= 1'b0;
      adc_q <= 1'b0;
    end else if (ce_in) begin
      if (stat_wr) begin
        flag_q <= (flag_q & ~avs_writedata_in[`TCP_NFLAG-1:0]) | set_d;
      end else begin
        flag_q <= flag_q | set_d;
      end
      irq_q <= |(flag_q & ien_q);
      adc_q <= pwm & mt[0];
    end
  end

  // pin a: compare output, plain io in pwm mode
  function [0:0] act;
    input cur;
    input [1:0] code;
    begin
      case (code)
        `TCP_ACT_HOLD: act = cur;
        `TCP_ACT_LOW: act = 1'b0;
        `TCP_ACT_HIGH: act = 1'b1;
        default: act = ~cur;
      endcase
    end
  endfunction

  reg pa_d;
  always @* begin
    pa_d = pin_a_q;
    if (mt[0]) begin
      pa_d = act(pa_d, ioc_q[`TCP_IOC_A]);
    end
    if (mt[2] & ~ioc_q[`TCP_IOC_SELC]) begin
      pa_d = act(pa_d, ioc_q[`TCP_IOC_C]);
    end
  end

  assign oe_a_d = ~pwm & ((ioc_q[`TCP_IOC_A] != `TCP_ACT_HOLD) |
                  (~ioc_q[`TCP_IOC_SELC] & (ioc_q[`TCP_IOC_C] != `TCP_ACT_HOLD)));
  assign pin_q[0] = pin_a_q;
  assign oe_q[0] = oe_a_q;

  always @(posedge mclk_in) begin
    if (srst_in) begin
      pin_a_q <= 1'b0;
      oe_a_q <= 1'b0;
    end else if (ce_in) begin
      oe_a_q <= oe_a_d;
      // initial level of pin a is ignored in pwm mode
      if (ctl1_wr & ~pwm) begin
        pin_a_q <= avs_writedata_in[`TCP_C1_TOA];
      end else if (~pwm) begin
        pin_a_q <= pa_d;
      end
    end
  end

  // pins b, c, d
  wire [2:0] pol;
  wire [2:0] pen;
  assign pol = ccr2_q[`TCP_CCR2_POL];
  assign pen = mode_q[`TCP_M_PEN] &
               {~mode_q[`TCP_M_BFD], ~mode_q[`TCP_M_BFC], 1'b1};
  generate
    for (g = 1; g < 4; g = g + 1) begin : g_pin
      reg nx;
      reg pin_x_q;
      reg oe_x_q;
      wire own;
      wire sec;

      assign pin_q[g] = pin_x_q;
      assign oe_q[g] = oe_x_q;

      if (g == 1) begin : g_b
        assign own = mt[1];
        assign sec = mt[3] & ~ioc_q[`TCP_IOC_SELD];
      end else begin : g_cd
        assign own = mt[g] & ioc_q[`TCP_IOC_SELC + g - 2];
        assign sec = 1'b0;
      end
      always @* begin
        nx = pin_x_q;
        if (pwm) begin
          if (mt[g] & (gr_q[g] != gr_q[0])) begin
            nx = pol[g-1];
          end
          // change point equal to period keeps the pin as it is
          if (mt[0] & (gr_q[g] != gr_q[0])) begin
            nx = ~pol[g-1];
          end
        end else begin
          if (own) begin
            nx = act(nx, ioc_q[2*g+1:2*g]);
          end
          if (sec) begin
            nx = act(nx, ioc_q[`TCP_IOC_D]);
          end
        end
      end

      always @(posedge mclk_in) begin
        if (srst_in) begin
          pin_x_q <= 1'b0;
          oe_x_q <= 1'b0;
        end else if (ce_in) begin
          oe_x_q <= pwm ? (pen[g-1] & ~cut_act)
                        : (ioc_q[2*g+1:2*g] != `TCP_ACT_HOLD);
          if (ctl1_wr) begin
            pin_x_q <= ~(avs_writedata_in[g] ^ pol[g-1]);
          end else if (~pwm | pen[g-1]) begin
            pin_x_q <= nx;
          end
        end
      end
    end
  endgenerate
endmodule

// File: tb/tcp_monitor.sv
// tcp_monitor.sv: bus and pin checks on the compare timer ports
// assumes one clock, sync reset, bound to the top module
`timescale 1ns/1ps
`include "tcp_defs.vh"
module tcp_monitor (
  input wire mclk_in,
  input wire srst_in,
  input wire ce_in,
  input wire [11:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [3:0] output_pin_oe_out,
  input wire adc_trigger_out,
  input wire irq_out
);
  logic [7:0] ccr2_q;
  logic ien_q;
  wire rd_ccr2 = avs_read_in && !avs_waitrequest_out && avs_address_in == `TCP_A_CCR2;
  always @(posedge mclk_in) begin
    if (srst_in) begin
      ccr2_q <= 8'h18;
      ien_q <= 1'b0;
    end else if (ce_in && avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in == `TCP_A_CCR2) ccr2_q <= avs_writedata_in[7:0];
      if (avs_address_in == `TCP_A_IEN) ien_q <= |avs_writedata_in[5:0];
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  AST_RST_OUT: assert property ($fell(srst_in) |-> avs_waitrequest_out &&
    output_pin_oe_out == 4'h0 && !irq_out && !adc_trigger_out) else $error("outputs not reset");
  AST_TAKE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in
    |=> !avs_waitrequest_out) else $error("request not answered in one cycle");
  AST_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  AST_IDLE: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("answer without request");
  AST_ONES: assert property (rd_ccr2 |-> avs_readdata_out[4:3] == 2'b11)
    else $error("unused bits not one");
  AST_RDBACK: assert property (rd_ccr2 |-> avs_readdata_out[7:0] == (ccr2_q | 8'h18))
    else $error("control two readback wrong");
  AST_UPPER: assert property (rd_ccr2 |-> avs_readdata_out[31:8] == 24'h0)
    else $error("control two upper bits not zero");
  AST_UNMAP: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in == 12'h1F0 |-> avs_readdata_out == 32'h0) else $error("unmapped read");
  AST_ADC: assert property (adc_trigger_out |=> !adc_trigger_out)
    else $error("adc trigger longer than one cycle");
  AST_IRQ: assert property (!ien_q && !$past(ien_q) |-> !irq_out)
    else $error("irq with enables clear");
endmodule
bind tcp_timer_compare_pwm_unit tcp_monitor u_mon (.mclk_in, .srst_in, .ce_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
  .avs_waitrequest_out, .output_pin_oe_out, .adc_trigger_out, .irq_out);

// File: tb/tcp_load_model.sv
// tcp_load_model.sv: load on the pwm pins, measures run lengths
// assumes pins sampled on the system clock
`timescale 1ns/1ps
module tcp_load_model (
  input wire clk_in,
  input wire rst_in,
  input wire [3:0] pin_in,
  output logic [15:0] hi_len_out,
  output logic [15:0] lo_len_out,
  output logic [15:0] c_edges_out
);
  logic prev_b_q;
  logic prev_c_q;
  logic [15:0] run_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      prev_b_q <= 1'b0;
      prev_c_q <= 1'b0;
      run_q <= 16'h0;
      hi_len_out <= 16'h0;
      lo_len_out <= 16'h0;
      c_edges_out <= 16'h0;
    end else begin
      prev_b_q <= pin_in[1];
      prev_c_q <= pin_in[2];
      if (pin_in[2] !== prev_c_q) c_edges_out <= c_edges_out + 16'h1;
      if (pin_in[1] !== prev_b_q) begin
        if (prev_b_q) hi_len_out <= run_q;
        else lo_len_out <= run_q;
        run_q <= 16'h1;
      end else begin
        run_q <= run_q + 16'h1;
      end
    end
  end
endmodule

// File: tb/tb_timer_compare_pwm_unit.sv
// tb_timer_compare_pwm_unit.sv: register and pwm tests of the compare timer
// assumes the bound monitor and the pin load model
`timescale 1ns/1ps
`include "tcp_defs.vh"
module tb_timer_compare_pwm_unit;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [11:0] addr = 12'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic trig = 1'b0;
  logic [31:0] v;
  logic [31:0] c0;
  wire [31:0] rdata;
  wire waitreq;
  wire [3:0] pins;
  wire irq;
  wire [15:0] hi_len;
  wire [15:0] lo_len;
  wire [15:0] c_edges;
  int err_count = 0;
  int samples_checked = 0;
  always #25 mclk_in = ~mclk_in;
  tcp_timer_compare_pwm_unit u_dut (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'b1),
    .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .external_count_clock_pin_in(1'b0), .fast_osc_clock_in(1'b0),
    .divided_osc_clock_in(1'b0), .trigger_input_pin_in(trig), .cutoff_in(1'b0),
    .output_pin_out(pins), .output_pin_oe_out(), .adc_trigger_out(), .irq_out(irq));
  tcp_load_model u_load (.clk_in(mclk_in), .rst_in(srst_in), .pin_in(pins),
    .hi_len_out(hi_len), .lo_len_out(lo_len), .c_edges_out(c_edges));
  task results();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 40);
    if (n >= 40) err_count++;
    v = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge mclk_in);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(v, exp);
  endtask
  task idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  initial begin
    repeat (5000) @(posedge mclk_in);
    err_count++;
    results();
  end
  initial begin
    idle(12);
    srst_in <= 1'b0;
    idle(1);
    chk(`TCP_A_CCR2, 32'h18);
    wr(`TCP_A_CCR2, 32'h0);
    chk(`TCP_A_CCR2, 32'h18);
    wr(`TCP_A_CCR2, 32'h27);
    chk(`TCP_A_CCR2, 32'h3F);
    chk(12'h1F0, 32'h0);
    wr(`TCP_A_CNT, 32'h1234);
    idle(5);
    chk(`TCP_A_CNT, 32'h1234);
    wr(`TCP_A_MODE, 32'h1);
    idle(5);
    wr(`TCP_A_MODE, 32'h0);
    bus(1'b0, `TCP_A_CNT, 32'h0);
    check({31'h0, v > 32'h1234}, 32'h1);
    for (int e = 0; e < 4; e++) begin
      wr(`TCP_A_CCR2, {24'h0, e[1:0], 6'h0});
      wr(`TCP_A_STAT, 32'h3F);
      trig <= 1'b1;
      idle(8);
      bus(1'b0, `TCP_A_STAT, 32'h0);
      check({31'h0, v[5]}, {31'h0, e == 1 || e == 3});
      wr(`TCP_A_STAT, 32'h3F);
      trig <= 1'b0;
      idle(8);
      bus(1'b0, `TCP_A_STAT, 32'h0);
      check({31'h0, v[5]}, {31'h0, e >= 2});
    end
    wr(`TCP_A_GRA, 32'h9);
    wr(`TCP_A_GRB, 32'h3);
    wr(`TCP_A_GRC, 32'h9);
    for (int p = 0; p < 2; p++) begin
      wr(`TCP_A_CCR2, {31'h0, p[0]});
      wr(`TCP_A_CTL1, 32'h4);
      wr(`TCP_A_CNT, 32'h0);
      c0 = {16'h0, c_edges};
      wr(`TCP_A_MODE, 32'h33);
      idle(90);
      check({16'h0, hi_len}, p ? 32'h6 : 32'h4);
      check({16'h0, lo_len}, p ? 32'h4 : 32'h6);
      check({16'h0, c_edges}, c0);
      check({31'h0, pins[2]}, 32'h0);
      wr(`TCP_A_MODE, 32'h32);
      bus(1'b0, `TCP_A_CNT, 32'h0);
      c0 = v;
      idle(10);
      chk(`TCP_A_CNT, c0);
    end
    bus(1'b0, `TCP_A_STAT, 32'h0);
    check(v & 32'h3, 32'h3);
    wr(`TCP_A_IEN, 32'h1);
    idle(3);
    check({31'h0, irq}, 32'h1);
    wr(`TCP_A_IEN, 32'h0);
    idle(3);
    check({31'h0, irq}, 32'h0);
    wr(`TCP_A_STAT, 32'h3F);
    chk(`TCP_A_STAT, 32'h0);
    wr(`TCP_A_CCR2, 32'h21);
    wr(`TCP_A_CNT, 32'h0);
    wr(`TCP_A_MODE, 32'h33);
    idle(40);
    chk(`TCP_A_CNT, 32'h9);
    chk(`TCP_A_MODE, 32'h32);
    wr(`TCP_A_CCR2, 32'h0);
    wr(`TCP_A_MODE, 32'h0);
    wr(`TCP_A_IOC, 32'h48);
    wr(`TCP_A_GRC, 32'h5);
    wr(`TCP_A_GRD, 32'h7);
    wr(`TCP_A_CTL1, 32'h80);
    wr(`TCP_A_CNT, 32'h0);
    wr(`TCP_A_MODE, 32'h1);
    idle(50);
    check({16'h0, hi_len}, 32'h4);
    check({16'h0, lo_len}, 32'h6);
    results();
  end
endmodule
